// >>> src/kpi_defs.svh
// constants of the keypad pin interrupt block: offsets, fields, resets
// assumes a 32-bit AXI4-Lite register bus and six keypad pins
// Functional notes
// - each pin has its own enable bit
// - polarity 1 rising/high, 0 falling/low
// - enabled pin gets pull-up or pull-down by polarity
// - asserted enabled inputs set the shared latch
// - edge mode ignores edge while another asserted
// - sensitivity bit 1 edge-and-level, 0 edge
// - level mode clears after deassert and acknowledge
// - vector-fetch acknowledge clears the latch
// - edge after acknowledge latches fresh request
// - reset clears request and sensitivity bit
// - edge mode acknowledge clears at once
// - pending flag shows latch, ignores mask
// - mask bit blocks the cpu request
// - detection continues in wait and stop
// - enabled pin forced to input direction
// - break state blocks acknowledges unless clear-enabled
`ifndef KPI_DEFS_SVH
`define KPI_DEFS_SVH
`define KPI_NPIN        6
`define KPI_OFS_STATUS  8'h00
`define KPI_OFS_ENABLE  8'h04
`define KPI_OFS_POLAR   8'h08
`define KPI_BIT_PEND    3
`define KPI_BIT_ACK     2
`define KPI_BIT_MASK    1
`define KPI_BIT_SENS    0
`define KPI_RST_MASK    1'h0
`define KPI_RST_SENS    1'h0
`define KPI_RST_PINS    6'h00
`define KPI_RESP_OKAY   2'h0
`define KPI_RESP_SLVERR 2'h2
`endif

// >>> src/kpi_pkg.sv
// types shared by the keypad pin interrupt files
// assumes kpi_defs.svh for field widths
`include "kpi_defs.svh"
package kpi_pkg;
  typedef enum logic [1:0] {
    KPI_IDLE = 2'h0,
    KPI_RESP = 2'h1
  } kpi_bus_type;
endpackage : kpi_pkg

// >>> src/kpi_det_if.sv
// detector carrier between the register side and the pin detector
// assumes one clock domain
`timescale 1ns/10ps
interface kpi_det_if;
  logic [5:0] en;       // pin enables
  logic [5:0] pol;      // pin polarities
  logic [5:0] asserted; // polarity-corrected level
  logic [5:0] edge_hit; // polarity-corrected active edge
  modport ctl (output en, output pol, input asserted, input edge_hit);
  modport det (input en, input pol, output asserted, output edge_hit);
endinterface : kpi_det_if

// >>> src/kpi_pin_det.sv
// per-pin synchroniser and edge detector
// assumes pins asynchronous to clk_sys in practice
`timescale 1ns/10ps
`include "kpi_defs.svh"
module kpi_pin_det
  import kpi_pkg::*;
(
  input wire logic               clk_sys, // system clock
  input wire logic               nrst,    // async reset, active low
  input wire logic [5:0]         pin_in,  // raw pin levels
  kpi_det_if.det                 det      // detector carrier
);
  typedef struct packed {
    logic [5:0] s1;   // first synchroniser stage
    logic [5:0] s2;   // second stage
    logic [5:0] prev; // previous corrected sample
  } kpi_det_type;
  kpi_det_type st_reg, st_next;
  logic [5:0] corr;

  // polarity correction: 1 means active
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    corr = st_reg.s2 ^ ~det.pol;
    st_next.prev = corr;
  end

  // edge only from stable samples so s1 stays private
  genvar i;
  generate
    for (i = 0; i < `KPI_NPIN; i++) begin : g_pin
      assign det.asserted[i] = det.en[i] & corr[i];
      assign det.edge_hit[i] = det.en[i] & corr[i] & ~st_reg.prev[i];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : kpi_pin_det

// >>> src/kpi_top.sv
// keypad pin interrupt controller with AXI4-Lite registers
// assumes single clock clk_sys, cpu supplies vector-fetch pulse and break
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "kpi_defs.svh"
module kpi_top
  import kpi_pkg::*;
(
  input  wire logic        clk_sys,     // 40 MHz system clock
  input  wire logic        nrst,        // async reset, active low
  input  wire logic [7:0]  s_awaddr,    // write address
  input  wire logic        s_awvalid,   // write address valid
  output logic             s_awready,   // write address ready
  input  wire logic [31:0] s_wdata,     // write data
  input  wire logic [3:0]  s_wstrb,     // write strobes
  input  wire logic        s_wvalid,    // write data valid
  output logic             s_wready,    // write data ready
  output logic [1:0]       s_bresp,     // write response
  output logic             s_bvalid,    // write response valid
  input  wire logic        s_bready,    // write response ready
  input  wire logic [7:0]  s_araddr,    // read address
  input  wire logic        s_arvalid,   // read address valid
  output logic             s_arready,   // read address ready
  output logic [31:0]      s_rdata,     // read data
  output logic [1:0]       s_rresp,     // read response
  output logic             s_rvalid,    // read data valid
  input  wire logic        s_rready,    // read data ready
  input  wire logic [5:0]  pin_in,      // keypad pin levels
  output logic [5:0]       pull_up_en,  // pull-up enables
  output logic [5:0]       pull_dn_en,  // pull-down enables
  output logic [5:0]       force_input, // direction override
  input  wire logic        vector_ack,  // vector fetch pulse
  input  wire logic        break_state, // debug break active
  input  wire logic        break_clear_enable, // clears allowed in break
  output logic             irq_req,     // cpu request, active high
  output logic             wake_req     // wakeup from wait/stop
);
  typedef struct packed {
    kpi_bus_type wst;      // write channel state
    kpi_bus_type rst;      // read channel state
    logic        aw_got;   // address taken
    logic        w_got;    // data taken
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [5:0]  pin_en;   // keypad_pin_enable
    logic [5:0]  pin_pol;  // keypad_pin_polarity
    logic        mask;     // request_mask
    logic        sens;     // sensitivity_select
    logic        latch;    // pending latch
    logic        acked;    // level mode acknowledge seen
  } kpi_state_type;
  kpi_state_type st_reg, st_next;

  // every check below runs on the system clock and rests during reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  kpi_det_if det_c ();
  logic        wr_fire, rd_fire, sw_ack, ack_ok, any_asserted, any_edge;
  logic        edge_ok, level_hold;
  logic [5:0]  others;

  kpi_pin_det u_det (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pin_in  (pin_in),
    .det     (det_c.det)
  );

  assign det_c.en  = st_reg.pin_en;
  assign det_c.pol = st_reg.pin_pol;

  // handshake outputs straight from state
  assign s_awready = (st_reg.wst == KPI_IDLE) & ~st_reg.aw_got;
  assign s_wready  = (st_reg.wst == KPI_IDLE) & ~st_reg.w_got;
  assign s_bvalid  = (st_reg.wst == KPI_RESP);
  assign s_bresp   = st_reg.bresp;
  assign s_arready = (st_reg.rst == KPI_IDLE);
  assign s_rvalid  = (st_reg.rst == KPI_RESP);
  assign s_rdata   = st_reg.rdata;
  assign s_rresp   = st_reg.rresp;

  // pull device by polarity on enabled pins only
  assign pull_up_en  = st_reg.pin_en & ~st_reg.pin_pol;
  assign pull_dn_en  = st_reg.pin_en & st_reg.pin_pol;
  assign force_input = st_reg.pin_en;

  // mask gates request and wake but not the flag; wake path needs clk_sys to set the latch
  assign irq_req  = st_reg.latch & ~st_reg.mask;
  assign wake_req = st_reg.latch & ~st_reg.mask;

  // write complete once both halves are held
  assign wr_fire = (st_reg.wst == KPI_IDLE) & st_reg.aw_got & st_reg.w_got;
  assign rd_fire = s_arvalid & s_arready;

  assign any_asserted = |det_c.asserted;

  // in edge mode an edge counts only when no other enabled pin already asserted
  genvar i;
  generate
    for (i = 0; i < `KPI_NPIN; i++) begin : g_oth
      assign others[i] = |(det_c.asserted & ~(6'h01 << i));
    end
  endgenerate
  assign edge_ok  = |(det_c.edge_hit & ~others);
  assign any_edge = st_reg.sens ? |det_c.edge_hit : edge_ok;

  // software acknowledge: write 1 to ack bit in byte 0
  assign sw_ack = wr_fire & (st_reg.awaddr == `KPI_OFS_STATUS)
                & st_reg.wstrb[0] & st_reg.wdata[`KPI_BIT_ACK];
  // break state blocks acknowledge clears unless enabled
  assign ack_ok = (vector_ack | sw_ack)
                & (~break_state | break_clear_enable);
  assign level_hold = st_reg.sens & any_asserted;

  // next state of bus and interrupt logic
  always_comb begin
    st_next = st_reg;
    if (s_awvalid & s_awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_awaddr;
    end
    if (s_wvalid & s_wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_wdata;
      st_next.wstrb = s_wstrb;
    end
    if (wr_fire) begin
      st_next.wst    = KPI_RESP;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bresp  = `KPI_RESP_OKAY;
      case (st_reg.awaddr)
        `KPI_OFS_STATUS: begin
          if (st_reg.wstrb[0]) begin
            st_next.mask = st_reg.wdata[`KPI_BIT_MASK];
            st_next.sens = st_reg.wdata[`KPI_BIT_SENS];
          end
        end
        `KPI_OFS_ENABLE: begin
          if (st_reg.wstrb[0]) begin
            st_next.pin_en = st_reg.wdata[5:0];
          end
        end
        `KPI_OFS_POLAR: begin
          if (st_reg.wstrb[0]) begin
            st_next.pin_pol = st_reg.wdata[5:0];
          end
        end
        default: st_next.bresp = `KPI_RESP_SLVERR;
      endcase
    end
    if ((st_reg.wst == KPI_RESP) & s_bready) begin
      st_next.wst = KPI_IDLE;
    end
    if (rd_fire) begin
      st_next.rst   = KPI_RESP;
      st_next.rresp = `KPI_RESP_OKAY;
      st_next.rdata = 32'h0;
      case (s_araddr)
        `KPI_OFS_STATUS: begin
          // ack bit reads zero, flag shows latch
          st_next.rdata[`KPI_BIT_PEND] = st_reg.latch;
          st_next.rdata[`KPI_BIT_MASK] = st_reg.mask;
          st_next.rdata[`KPI_BIT_SENS] = st_reg.sens;
        end
        `KPI_OFS_ENABLE: st_next.rdata[5:0] = st_reg.pin_en;
        `KPI_OFS_POLAR:  st_next.rdata[5:0] = st_reg.pin_pol;
        default:         st_next.rresp = `KPI_RESP_SLVERR;
      endcase
    end
    if ((st_reg.rst == KPI_RESP) & s_rready) begin
      st_next.rst = KPI_IDLE;
    end
    // latch: acknowledge clears, new event wins
    // acked only means something in level mode; kept clear otherwise so
    // a stale acknowledge cannot drop a later level request
    if (ack_ok) begin
      st_next.latch = 1'b0;
      st_next.acked = st_next.sens;
    end
    // second step of a level clear, in either order
    if (st_reg.sens & st_reg.acked & ~any_asserted) begin
      st_next.latch = 1'b0;
      st_next.acked = 1'b0;
    end
    if (level_hold) begin
      st_next.latch = 1'b1;
    end
    if (any_edge) begin
      st_next.latch = 1'b1;
      st_next.acked = 1'b0;
    end
  end

  // all state on every edge, also in wait and stop
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg      <= '0;
      st_reg.mask <= `KPI_RST_MASK;
      st_reg.sens <= `KPI_RST_SENS;
    end else begin
      st_reg <= st_next;
    end
  end

  // cpu request and wakeup both follow the latch, gated only by the mask
  a_mask_gate: assert property (
    irq_req == (st_reg.latch & ~st_reg.mask) && wake_req == irq_req)
    else $error("irq not gated by mask");

  sequence s_ack_edge_mode;
    !st_reg.sens && ack_ok && !any_edge;
  endsequence
  a_edge_clear: assert property (
    s_ack_edge_mode |=> !st_reg.latch)
    else $error("edge mode ack did not clear");

  a_level_hold: assert property (
    level_hold |=> st_reg.latch)
    else $error("level request dropped while asserted");

  // both steps of a level clear seen: acknowledge, then all pins released
  sequence s_level_released;
    st_reg.sens && st_reg.acked && !any_asserted;
  endsequence
  a_level_clear: assert property (
    s_level_released |=> !st_reg.latch)
    else $error("level request kept after release");

  a_edge_sets: assert property (
    any_edge |=> st_reg.latch)
    else $error("edge did not set latch");

  // a vector fetch outside break clears when nothing new arrives
  a_vec_clear: assert property (
    vector_ack && !break_state && !any_edge && !level_hold
    |=> !st_reg.latch)
    else $error("vector fetch did not clear");

  sequence s_sw_ack_free;
    sw_ack && (!break_state || break_clear_enable)
      && !any_edge && !level_hold;
  endsequence
  a_sw_ack_clear: assert property (
    s_sw_ack_free |=> !st_reg.latch)
    else $error("acknowledge write did not clear");

  a_break_prot: assert property (
    break_state && !break_clear_enable && st_reg.latch |=> st_reg.latch)
    else $error("status cleared in protected break");

  a_pull_sel: assert property (
    (pull_up_en & pull_dn_en) == 6'h00
      && (pull_up_en | pull_dn_en) == st_reg.pin_en)
    else $error("pull device wrong");

  a_edge_block: assert property (
    !st_reg.sens && !st_reg.latch && !edge_ok |=> !st_reg.latch)
    else $error("blocked edge latched");

  a_disabled_pin: assert property (
    st_reg.pin_en == 6'h00 && !st_reg.latch |=> !st_reg.latch)
    else $error("disabled pins set latch");

  // status read: the ack bit never reads back, pending shows the latch
  sequence s_status_read;
    rd_fire && s_araddr == `KPI_OFS_STATUS;
  endsequence
  a_ack_reads0: assert property (
    s_status_read |=> !s_rdata[`KPI_BIT_ACK])
    else $error("ack bit read back set");

  a_flag_read: assert property (
    s_status_read |=> s_rdata[`KPI_BIT_PEND] == $past(st_reg.latch))
    else $error("pending flag not the latch");

  // status write lands in mask and sensitivity on the next edge
  sequence s_status_write;
    wr_fire && st_reg.awaddr == `KPI_OFS_STATUS && st_reg.wstrb[0];
  endsequence
  a_sens_write: assert property (
    s_status_write |=> st_reg.sens == $past(st_reg.wdata[`KPI_BIT_SENS])
      && st_reg.mask == $past(st_reg.wdata[`KPI_BIT_MASK]))
    else $error("status write not applied");

  a_en_write: assert property (
    wr_fire && st_reg.awaddr == `KPI_OFS_ENABLE && st_reg.wstrb[0]
    |=> st_reg.pin_en == $past(st_reg.wdata[5:0]))
    else $error("enable write not applied");

  // unmapped offsets answer with an error and leave the pins alone
  a_unmapped_wr: assert property (
    wr_fire && st_reg.awaddr != `KPI_OFS_STATUS
      && st_reg.awaddr != `KPI_OFS_ENABLE
      && st_reg.awaddr != `KPI_OFS_POLAR
    |=> s_bresp == `KPI_RESP_SLVERR && $stable(st_reg.pin_en)
      && $stable(st_reg.pin_pol))
    else $error("unmapped write not refused");
endmodule : kpi_top

// >>> tb/kpi_keys.sv
// keypad switch model standing on the pin inputs
// assumes the device pulls and a free-running clock
`timescale 1ns/10ps
module kpi_keys (
  input  wire logic       clk_sys,    // system clock
  input  wire logic [5:0] press,      // switch closed
  input  wire logic [5:0] act,        // level a closed switch forces
  input  wire logic [5:0] pull_up_en, // device pull-ups
  input  wire logic [5:0] pull_dn_en, // device pull-downs
  output logic      [5:0] pin_in      // pin levels
);
  logic [5:0] float_reg = 6'h2A; // an open, unpulled pin wanders
  // undriven pins must never look stable to the detector
  always @(posedge clk_sys) begin
    float_reg <= ~float_reg;
  end
  // closed switch wins, then the pull, else floating
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = press[i] ? act[i] : pull_up_en[i] ? 1'b1 :
                  pull_dn_en[i] ? 1'b0 : float_reg[i];
    end
  end
endmodule : kpi_keys

// >>> tb/kpi_top_tb.sv
// self-checking bench for the keypad pin interrupt block
// assumes kpi_top, kpi_keys and the shared constants header
`timescale 1ns/10ps
`include "kpi_defs.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module kpi_top_tb import kpi_pkg::*;;
  localparam logic [31:0] ACK = 32'h1 << `KPI_BIT_ACK;
  localparam logic [31:0] MSK = 32'h1 << `KPI_BIT_MASK;
  localparam logic [31:0] SNS = 32'h1 << `KPI_BIT_SENS;
  logic clk_sys = 0, nrst = 0, vector_ack = 0;
  logic break_state = 0, break_clear_enable = 0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic s_arvalid = 0, s_rready = 0, irq_req, wake_req;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, rdv;
  logic [3:0] s_wstrb = 4'hF;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [5:0] pin_in, pull_up_en, pull_dn_en, force_input;
  logic [5:0] press = 0, act = 6'h15; // act matches programmed polarity
  int n_fail = 0, checks_done = 0;
  kpi_top dut (
    .clk_sys            (clk_sys),
    .nrst               (nrst),
    .s_awaddr           (s_awaddr),
    .s_awvalid          (s_awvalid),
    .s_awready          (s_awready),
    .s_wdata            (s_wdata),
    .s_wstrb            (s_wstrb),
    .s_wvalid           (s_wvalid),
    .s_wready           (s_wready),
    .s_bresp            (s_bresp),
    .s_bvalid           (s_bvalid),
    .s_bready           (s_bready),
    .s_araddr           (s_araddr),
    .s_arvalid          (s_arvalid),
    .s_arready          (s_arready),
    .s_rdata            (s_rdata),
    .s_rresp            (s_rresp),
    .s_rvalid           (s_rvalid),
    .s_rready           (s_rready),
    .pin_in             (pin_in),
    .pull_up_en         (pull_up_en),
    .pull_dn_en         (pull_dn_en),
    .force_input        (force_input),
    .vector_ack         (vector_ack),
    .break_state        (break_state),
    .break_clear_enable (break_clear_enable),
    .irq_req            (irq_req),
    .wake_req           (wake_req)
  );
  kpi_keys keys (
    .clk_sys    (clk_sys),
    .press      (press),
    .act        (act),
    .pull_up_en (pull_up_en),
    .pull_dn_en (pull_dn_en),
    .pin_in     (pin_in)
  );
  // free-running 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // write: both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid && n < 64);
    `CHK("bvalid", 1'b1, s_bvalid)
    rsp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  // read: data and response taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid && n < 64);
    `CHK("rvalid", 1'b1, s_rvalid)
    rdv = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  task automatic st(input logic [3:0] e);
    rd(`KPI_OFS_STATUS);
    `CHK("status", e, rdv[3:0])
  endtask : st
  // pin change then enough edges for sync, compare and latch
  task automatic key(input logic [5:0] p);
    @(posedge clk_sys);
    press <= p;
    repeat (5) @(posedge clk_sys);
  endtask : key
  task automatic vack;
    @(posedge clk_sys);
    vector_ack <= 1'b1;
    @(posedge clk_sys);
    vector_ack <= 1'b0;
  endtask : vack
  task automatic t_reset;
    st(4'h0);
    rd(`KPI_OFS_ENABLE);
    `CHK("enable", 6'h00, rdv[5:0])
    `CHK("irq", 1'b0, irq_req)
  endtask : t_reset
  task automatic t_regs;
    wr(`KPI_OFS_ENABLE, 32'h3F);
    wr(`KPI_OFS_POLAR, 32'h15);
    `CHK("pullup", 6'h2A, pull_up_en)
    `CHK("pulldn", 6'h15, pull_dn_en)
    `CHK("forcein", 6'h3F, force_input)
    rd(`KPI_OFS_POLAR);
    `CHK("polar", 6'h15, rdv[5:0])
    wr(8'h0C, 32'hFF);
    `CHK("bresp", `KPI_RESP_SLVERR, rsp)
    rd(8'h0C);
    `CHK("rresp", `KPI_RESP_SLVERR, rsp)
    // bring-up order: mask, polarity, enable, ack, unmask
    wr(`KPI_OFS_STATUS, MSK);
    wr(`KPI_OFS_POLAR, 32'h15);
    wr(`KPI_OFS_ENABLE, 32'h03);
    wr(`KPI_OFS_STATUS, ACK | MSK);
    wr(`KPI_OFS_STATUS, 32'h0);
    `CHK("pullup", 6'h02, pull_up_en)
  endtask : t_regs
  task automatic t_edge;
    key(6'h01);
    `CHK("irq", 1'b1, irq_req)
    `CHK("wake", 1'b1, wake_req)
    st(4'h8);
    wr(`KPI_OFS_STATUS, ACK);
    st(4'h0);
    key(6'h00);
    key(6'h02);
    st(4'h8);
    wr(`KPI_OFS_STATUS, ACK);
    key(6'h00);
  endtask : t_edge
  task automatic t_block;
    key(6'h02);
    wr(`KPI_OFS_STATUS, ACK);
    key(6'h03);
    st(4'h0);
    key(6'h00);
    key(6'h20);
    st(4'h0);
  endtask : t_block
  task automatic t_mask;
    wr(`KPI_OFS_STATUS, MSK);
    key(6'h01);
    `CHK("irq", 1'b0, irq_req)
    st(4'hA);
    vack;
    st(4'h2);
    key(6'h00);
    wr(`KPI_OFS_STATUS, 32'h0);
  endtask : t_mask
  task automatic t_level;
    wr(`KPI_OFS_STATUS, SNS);
    key(6'h02);
    wr(`KPI_OFS_STATUS, ACK | SNS);
    st(4'h9);
    key(6'h00);
    st(4'h1);
    key(6'h02);
    key(6'h00);
    st(4'h9);
    wr(`KPI_OFS_STATUS, ACK | SNS);
    st(4'h1);
  endtask : t_level
  task automatic t_break;
    wr(`KPI_OFS_STATUS, 32'h0);
    key(6'h01);
    break_state <= 1'b1;
    wr(`KPI_OFS_STATUS, ACK);
    vack;
    st(4'h8);
    break_clear_enable <= 1'b1;
    wr(`KPI_OFS_STATUS, ACK);
    st(4'h0);
    break_state <= 1'b0;
    key(6'h00);
  endtask : t_break
  task automatic t_rst;
    wr(`KPI_OFS_STATUS, SNS);
    key(6'h02);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    st(4'h0);
    `CHK("irq", 1'b0, irq_req)
  endtask : t_rst
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_regs;
    t_edge;
    t_block;
    t_mask;
    t_level;
    t_break;
    t_rst;
    test_done;
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #(25 * 5000);
    n_fail++;
    test_done;
  end
endmodule : kpi_top_tb
